// *** hdl/_end_marker_unused.sv ***
`timescale 1ns/1ns

// *** hdl/bpmc_lvl_filter.sv ***
// two-flop synchroniser plus one-cycle glitch filter for level inputs
// assumes inputs are levels that change far slower than the clock
`timescale 1ns/1ns
module bpmc_lvl_filter (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    bpmc_lvl_if.filt  lvl
);
    import bpmc_pkg::*;

    logic [IN_W-1:0] meta_ff;
    logic [IN_W-1:0] sync_ff;
    logic [IN_W-1:0] prev_ff;
    logic [IN_W-1:0] clean_ff;

    // -----------------------------------------------------------------
    // synchroniser and agreement filter
    // -----------------------------------------------------------------
    // a bit moves only when two successive samples agree
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff  <= '0;
            sync_ff  <= '0;
            prev_ff  <= '0;
            clean_ff <= '0;
        end else begin
            meta_ff <= lvl.raw;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
            for (int i = 0; i < IN_W; i++) begin
                if (sync_ff[i] == prev_ff[i]) begin
                    clean_ff[i] <= sync_ff[i];
                end
            end
        end
    end

    assign lvl.clean = clean_ff;
endmodule

// *** hdl/bpmc_lvl_if.sv ***
// raw and filtered level inputs between the top and its filter
// assumes both ends sit on clk_sys_i
`timescale 1ns/1ns
interface bpmc_lvl_if;
    logic [bpmc_pkg::IN_W-1:0] raw;
    logic [bpmc_pkg::IN_W-1:0] clean;
    modport filt (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// *** hdl/bpmc_pkg.sv ***
// constants and types for the brushless drive control block
// assumes one 25 MHz clock and an apb master for the small register set
package bpmc_pkg;
    // -----------------------------------------------------------------
    // clock and timing
    // -----------------------------------------------------------------
    localparam int CLK_NS        = 40;
    localparam int OFF_SHORT_NS  = 2200;
    localparam int OFF_LONG_NS   = 7000;
    localparam int OFF_SHORT_CYC = (OFF_SHORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int OFF_LONG_CYC  = (OFF_LONG_NS + CLK_NS - 1) / CLK_NS;
    localparam int ZERO_DUTY_US  = 5000;
    localparam int ZERO_DUTY_CYC = ZERO_DUTY_US * 1000 / CLK_NS;
    localparam int MS_TICK_US    = 1000;
    localparam int MS_TICK_CYC   = MS_TICK_US * 1000 / CLK_NS;
    localparam int FILT_LAT_CYC  = 4;

    // -----------------------------------------------------------------
    // register map and fields
    // -----------------------------------------------------------------
    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_LOCK       = 8'h04;
    localparam logic [7:0]  OFF_STAT       = 8'h08;
    localparam logic        CTRL_RST       = 1'h0;
    localparam logic [15:0] LOCK_RST       = 16'h0fa0;
    localparam int          CTRL_MODE_BIT  = 0;
    localparam int          STAT_STATE_LSB = 0;
    localparam int          STAT_STEP_LSB  = 4;
    localparam int          STAT_TACH_BIT  = 8;
    localparam int          STAT_BRAKE_BIT = 9;
    localparam int          STAT_FWD_BIT   = 10;
    localparam int          STAT_VALID_BIT = 11;
    localparam int          STAT_HALL_LSB  = 12;

    // -----------------------------------------------------------------
    // positions in the filtered level vector
    // -----------------------------------------------------------------
    localparam int IN_HALL = 0;
    localparam int IN_TSEL = 3;
    localparam int IN_DEC  = 4;
    localparam int IN_BR   = 5;
    localparam int IN_BRO  = 6;
    localparam int IN_FR   = 7;
    localparam int IN_FRO  = 8;
    localparam int IN_PWM  = 9;
    localparam int IN_PWMO = 10;
    localparam int IN_VSPW = 11;
    localparam int IN_VSPO = 12;
    localparam int IN_W    = 13;

    localparam logic [2:0] UPPER_BRAKE_HS = 3'h3;

    typedef enum logic [1:0] {ST_SLEEP, ST_RUN, ST_FREE} bpmc_state_t;
    typedef enum logic {MODE_PWM, MODE_VSP} bpmc_mode_t;
endpackage

// *** hdl/bpmc_top.sv ***
// drive control logic of a three-phase brushless motor driver
// assumes analog comparators deliver hall, speed and current levels
`timescale 1ns/1ns
module bpmc_top #(
    parameter int ZERO_DUTY_CYC_P = bpmc_pkg::ZERO_DUTY_CYC,
    parameter int MS_TICK_CYC_P   = bpmc_pkg::MS_TICK_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [2:0]  hall_cmp_i,
    input  wire logic        tach_ratio_select_i,
    input  wire logic        decay_time_select_i,
    input  wire logic        coil_shorting_select_i,
    input  wire logic        coil_shorting_open_i,
    input  wire logic        rotation_sense_select_i,
    input  wire logic        rotation_sense_open_i,
    input  wire logic        pulse_width_drive_input_i,
    input  wire logic        pulse_width_open_i,
    input  wire logic        speed_wake_cmp_i,
    input  wire logic        speed_open_i,
    input  wire logic        cur_peak_i,
    input  wire logic        ocp_i,
    output logic      [2:0]  hs_on_o,
    output logic      [2:0]  ls_on_o,
    output logic             tach_pulse_out_o,
    output logic             sleep_state_o,
    output logic             regulator_en_o
);
    import bpmc_pkg::*;

    localparam logic [16:0] ZD_LAST   = 17'(ZERO_DUTY_CYC_P - 1);
    localparam logic [14:0] TICK_LAST = 15'(MS_TICK_CYC_P - 1);
    localparam logic [7:0]  OFF_SHORT = 8'(OFF_SHORT_CYC);
    localparam logic [7:0]  OFF_LONG  = 8'(OFF_LONG_CYC);

    // -----------------------------------------------------------------
    // functions
    // -----------------------------------------------------------------
    // hall code to {valid, step}
    function automatic logic [3:0] hall_step(input logic [2:0] code);
        unique case (code)
            3'h5:    hall_step = 4'h8;
            3'h4:    hall_step = 4'h9;
            3'h6:    hall_step = 4'ha;
            3'h2:    hall_step = 4'hb;
            3'h3:    hall_step = 4'hc;
            3'h1:    hall_step = 4'hd;
            default: hall_step = 4'h0;
        endcase
    endfunction

    // step and direction to {high sides, low sides}
    function automatic logic [5:0] comm(input logic [2:0] step, input logic fwd);
        logic [2:0] s;
        s = fwd ? step : ((step > 3'h2) ? step - 3'h3 : step + 3'h3);
        unique case (s)
            3'h0:    comm = {3'h1, 3'h2};
            3'h1:    comm = {3'h1, 3'h4};
            3'h2:    comm = {3'h2, 3'h4};
            3'h3:    comm = {3'h2, 3'h1};
            3'h4:    comm = {3'h4, 3'h1};
            3'h5:    comm = {3'h4, 3'h2};
            default: comm = 6'h00;
        endcase
    endfunction

    // -----------------------------------------------------------------
    // input filtering and effective levels
    // -----------------------------------------------------------------
    bpmc_lvl_if lvl ();

    logic [IN_W-1:0] cl;
    logic            brake_c;
    logic            fwd_c;
    logic            pwm_c;
    logic            pwm_open;
    logic            vsp_wake;
    logic [3:0]      hs_code;
    logic [5:0]      comm_w;
    logic            wake;

    assign lvl.raw = {speed_open_i, speed_wake_cmp_i, pulse_width_open_i,
                      pulse_width_drive_input_i, rotation_sense_open_i,
                      rotation_sense_select_i, coil_shorting_open_i,
                      coil_shorting_select_i, decay_time_select_i,
                      tach_ratio_select_i, hall_cmp_i};

    bpmc_lvl_filter u_filt (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .lvl       (lvl.filt)
    );

    assign cl       = lvl.clean;
    assign brake_c  = cl[IN_BR] | cl[IN_BRO];
    assign fwd_c    = cl[IN_FR] | cl[IN_FRO];
    assign pwm_c    = cl[IN_PWM] | cl[IN_PWMO];
    assign pwm_open = cl[IN_PWMO];
    assign vsp_wake = cl[IN_VSPW] & ~cl[IN_VSPO];
    assign hs_code  = hall_step(cl[IN_HALL +: 3]);
    assign comm_w   = comm(hs_code[2:0], fwd_c);

    // -----------------------------------------------------------------
    // apb registers
    // -----------------------------------------------------------------
    bpmc_mode_t      mode_ff;
    logic [15:0]     lock_time_ff;
    bpmc_state_t     state_ff;
    logic            tach_ff;
    logic            wr_en;
    logic            hit;
    logic [31:0]     rd_val;

    assign pready_o  = 1'b1;
    assign hit       = paddr_i == OFF_CTRL || paddr_i == OFF_LOCK || paddr_i == OFF_STAT;
    assign pslverr_o = psel_i & penable_i & ~hit;
    assign wr_en     = psel_i & penable_i & pwrite_i;

    // read mux, unmapped and reserved bits read zero
    always_comb begin
        rd_val = '0;
        unique case (paddr_i)
            OFF_CTRL: rd_val[CTRL_MODE_BIT] = mode_ff;
            OFF_LOCK: rd_val[15:0] = lock_time_ff;
            OFF_STAT: begin
                rd_val[STAT_STATE_LSB +: 2] = state_ff;
                rd_val[STAT_STEP_LSB +: 3]  = hs_code[2:0];
                rd_val[STAT_TACH_BIT]       = tach_ff;
                rd_val[STAT_BRAKE_BIT]      = brake_c;
                rd_val[STAT_FWD_BIT]        = fwd_c;
                rd_val[STAT_VALID_BIT]      = hs_code[3];
                rd_val[STAT_HALL_LSB +: 3]  = cl[IN_HALL +: 3];
            end
            default: rd_val = '0;
        endcase
    end

    // read data captured in the setup cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= '0;
        end else if (psel_i && !penable_i) begin
            prdata_o <= rd_val;
        end
    end

    // writable registers
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_ff      <= bpmc_mode_t'(CTRL_RST);
            lock_time_ff <= LOCK_RST;
        end else if (wr_en && paddr_i == OFF_CTRL) begin
            mode_ff <= bpmc_mode_t'(pwdata_i[CTRL_MODE_BIT]);
        end else if (wr_en && paddr_i == OFF_LOCK) begin
            lock_time_ff <= pwdata_i[15:0];
        end
    end

    // -----------------------------------------------------------------
    // timers
    // -----------------------------------------------------------------
    logic [16:0] zd_cnt_ff;
    logic [14:0] tick_cnt_ff;
    logic        ms_tick;
    logic [15:0] lock_cnt_ff;
    logic        fwd_d_ff;
    logic [7:0]  off_cnt_ff;
    logic        off_busy;
    logic        off_trig;

    // zero-duty timer, runs in run state and pwm mode while pwm stays high
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zd_cnt_ff <= '0;
        end else if (state_ff == ST_RUN && mode_ff == MODE_PWM && pwm_c) begin
            if (zd_cnt_ff != ZD_LAST) begin
                zd_cnt_ff <= zd_cnt_ff + 17'h1;
            end
        end else begin
            zd_cnt_ff <= '0;
        end
    end

    // millisecond enable for the lock timer
    assign ms_tick = tick_cnt_ff == TICK_LAST;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= ms_tick ? 15'h0 : tick_cnt_ff + 15'h1;
        end
    end

    // lock timer, restarts on brake or a direction change
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_cnt_ff <= '0;
            fwd_d_ff    <= 1'b1;
        end else begin
            fwd_d_ff <= fwd_c;
            if (state_ff != ST_FREE || brake_c || fwd_c != fwd_d_ff) begin
                lock_cnt_ff <= '0;
            end else if (ms_tick && lock_cnt_ff != 16'hffff) begin
                lock_cnt_ff <= lock_cnt_ff + 16'h1;
            end
        end
    end

    // fixed off time after a peak event in vsp mode or an overcurrent event in pwm mode
    assign off_busy = off_cnt_ff != 8'h0;
    assign off_trig = state_ff == ST_RUN && !off_busy &&
                      (mode_ff == MODE_VSP ? cur_peak_i : ocp_i);
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            off_cnt_ff <= '0;
        end else if (off_trig) begin
            off_cnt_ff <= cl[IN_DEC] ? OFF_SHORT : OFF_LONG;
        end else if (off_busy) begin
            off_cnt_ff <= off_cnt_ff - 8'h1;
        end
    end

    // -----------------------------------------------------------------
    // operating state
    // -----------------------------------------------------------------
    localparam logic [2:0] FILT_LAT = 3'(FILT_LAT_CYC);

    logic [2:0] prime_cnt_ff;
    logic       primed;

    // filter latency guard, reset levels of the filter are not real inputs
    assign primed = prime_cnt_ff == FILT_LAT;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prime_cnt_ff <= '0;
        end else if (!primed) begin
            prime_cnt_ff <= prime_cnt_ff + 3'h1;
        end
    end

    assign wake = primed && ((mode_ff == MODE_PWM) ? ~pwm_c : vsp_wake);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_SLEEP;
        end else begin
            unique case (state_ff)
                ST_SLEEP: begin
                    if (wake) begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (mode_ff == MODE_PWM ? (pwm_c && zd_cnt_ff == ZD_LAST)
                                            : !vsp_wake) begin
                        state_ff <= ST_FREE;
                    end
                end
                ST_FREE: begin
                    if (wake) begin
                        state_ff <= ST_RUN;
                    end else if (lock_time_ff != 16'h0 && lock_cnt_ff >= lock_time_ff) begin
                        state_ff <= ST_SLEEP;
                    end
                end
                default: state_ff <= ST_SLEEP;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // output stage
    // -----------------------------------------------------------------
    logic [2:0] nxt_hs;
    logic [2:0] nxt_ls;

    // brake first, then pwm gating, then the current loop off time
    always_comb begin
        nxt_hs = '0;
        nxt_ls = '0;
        if (state_ff != ST_SLEEP) begin
            if (brake_c) begin
                nxt_ls = 3'h7;
            end else if (state_ff == ST_RUN) begin
                if (mode_ff == MODE_PWM && pwm_open) begin
                    nxt_hs = '0;
                end else if (mode_ff == MODE_PWM && pwm_c) begin
                    nxt_hs = UPPER_BRAKE_HS;
                end else if (!off_busy && hs_code[3]) begin
                    {nxt_hs, nxt_ls} = comm_w;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hs_on_o        <= '0;
            ls_on_o        <= '0;
            tach_ff        <= 1'b0;
            regulator_en_o <= 1'b0;
        end else begin
            hs_on_o        <= nxt_hs;
            ls_on_o        <= nxt_ls;
            regulator_en_o <= state_ff != ST_SLEEP;
            // xor of three halls gives three cycles per hall cycle
            tach_ff <= cl[IN_TSEL] ? ^cl[IN_HALL +: 3] : cl[IN_HALL];
        end
    end

    assign tach_pulse_out_o = tach_ff;
    assign sleep_state_o    = state_ff == ST_SLEEP;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    localparam int OFF_SHORT_GAP = OFF_SHORT_CYC - 7;

    sequence s_zd_expire;
        state_ff == ST_RUN && mode_ff == MODE_PWM && pwm_c && zd_cnt_ff == ZD_LAST;
    endsequence

    sequence s_free_entry;
        state_ff == ST_FREE ##1 hs_on_o == 3'h0 && ls_on_o == ($past(brake_c) ? 3'h7 : 3'h0);
    endsequence

    brake_low_a: assert property (
        state_ff != ST_SLEEP && brake_c |=> ls_on_o == 3'h7 && hs_on_o == 3'h0)
        else $error("brake did not turn all low sides on");

    open_brake_a: assert property (
        cl[IN_BRO] && state_ff != ST_SLEEP |=> ls_on_o == 3'h7)
        else $error("open brake select not treated as high");

    open_fwd_a: assert property (
        cl[IN_FRO] && state_ff == ST_RUN && mode_ff == MODE_VSP && !brake_c && !off_busy
        && hs_code[3] |=> {hs_on_o, ls_on_o} == comm($past(hs_code[2:0]), 1'b1))
        else $error("open rotation select not forward");

    drive_step_a: assert property (
        state_ff == ST_RUN && mode_ff == MODE_PWM && !pwm_c && !brake_c && !off_busy
        && hs_code[3] |=> {hs_on_o, ls_on_o} == $past(comm_w))
        else $error("pwm low did not drive the commutation step");

    off_time_a: assert property (
        off_trig && cl[IN_DEC] |=> off_busy [*8] ##OFF_SHORT_GAP !off_busy)
        else $error("short off time length wrong");

    off_out_a: assert property (
        off_busy && !brake_c && state_ff == ST_RUN && !pwm_c |=> hs_on_o == 3'h0)
        else $error("high sides on during off time");

    zero_duty_a: assert property (
        s_zd_expire |=> s_free_entry)
        else $error("zero duty did not lead to free-run");

    upper_brake_a: assert property (
        state_ff == ST_RUN && mode_ff == MODE_PWM && pwm_c && !pwm_open && !brake_c
        |=> hs_on_o == UPPER_BRAKE_HS && ls_on_o == 3'h0)
        else $error("upper brake missing while pwm high");

    open_pwm_a: assert property (
        mode_ff == MODE_PWM && pwm_open && !brake_c |=> hs_on_o == 3'h0 && ls_on_o == 3'h0)
        else $error("open pwm input did not stop drive");

    wake_pwm_a: assert property (
        primed && state_ff == ST_SLEEP && mode_ff == MODE_PWM && !pwm_c
        |=> state_ff == ST_RUN ##1 regulator_en_o)
        else $error("pwm low did not wake");

    wake_vsp_a: assert property (
        primed && state_ff == ST_SLEEP && mode_ff == MODE_VSP && vsp_wake |=> !sleep_state_o)
        else $error("speed input did not wake");

    vsp_free_a: assert property (
        state_ff == ST_RUN && mode_ff == MODE_VSP && !vsp_wake |=> state_ff == ST_FREE)
        else $error("low speed input did not free-run");

    no_lock_a: assert property (
        state_ff == ST_FREE && lock_time_ff == 16'h0 |=> state_ff != ST_SLEEP)
        else $error("sleep entered without lock timer");

    tach_a: assert property (
        !cl[IN_TSEL] ##1 !cl[IN_TSEL] |-> tach_pulse_out_o == $past(cl[IN_HALL]))
        else $error("one-per-cycle tach does not follow hall");
endmodule

// *** sim/bpmc_hall_model.sv ***
// hall sensor model: turns a rotor sector index into comparator levels
// assumes the index is 0..5; any other index gives an invalid code
`timescale 1ns/1ns
module bpmc_hall_model (
    input  wire logic [2:0] sector_i,
    output logic      [2:0] hall_cmp_o
);
    // sector to code, bit0 = u, bit1 = v, bit2 = w
    always_comb begin
        case (sector_i)
            3'h0: hall_cmp_o = 3'h5;
            3'h1: hall_cmp_o = 3'h4;
            3'h2: hall_cmp_o = 3'h6;
            3'h3: hall_cmp_o = 3'h2;
            3'h4: hall_cmp_o = 3'h3;
            3'h5: hall_cmp_o = 3'h1;
            default: hall_cmp_o = 3'h7;
        endcase
    end
endmodule

// *** sim/bpmc_top_tb.sv ***
// self-checking bench for the drive control block
// assumes zero duty shortened to 50 cycles and the ms tick to 10 cycles
`timescale 1ns/1ns
module bpmc_top_tb;
    import bpmc_pkg::*;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er;
    logic [2:0] sector = 3'h0, hall, hs, ls;
    logic tsel = 1'b0, dec = 1'b1, brk = 1'b0, brk_open = 1'b0, fwd = 1'b1, fwd_open = 1'b0;
    logic pwm = 1'b1, pwm_open = 1'b0, wake = 1'b0, spd_open = 1'b0, peak = 1'b0, ocp = 1'b0;
    logic tach, sleep, reg_en;
    int err_count = 0, samples_checked = 0, cyc = 0, st;
    always #20 clk_sys_i = ~clk_sys_i;
    bpmc_hall_model hall_model (.sector_i(sector), .hall_cmp_o(hall));
    bpmc_top #(.ZERO_DUTY_CYC_P(50), .MS_TICK_CYC_P(10)) dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .hall_cmp_i(hall),
        .tach_ratio_select_i(tsel), .decay_time_select_i(dec),
        .coil_shorting_select_i(brk), .coil_shorting_open_i(brk_open),
        .rotation_sense_select_i(fwd), .rotation_sense_open_i(fwd_open),
        .pulse_width_drive_input_i(pwm), .pulse_width_open_i(pwm_open),
        .speed_wake_cmp_i(wake), .speed_open_i(spd_open), .cur_peak_i(peak), .ocp_i(ocp),
        .hs_on_o(hs), .ls_on_o(ls), .tach_pulse_out_o(tach), .sleep_state_o(sleep),
        .regulator_en_o(reg_en));
    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // expected {hs, ls} for a sector and direction
    function automatic logic [5:0] exp_drv(input logic [2:0] s, input logic f);
        logic [5:0] t [6] = '{6'h0a, 6'h0c, 6'h14, 6'h11, 6'h21, 6'h22};
        return t[f ? s : (s + 3) % 6];
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // filter takes four edges, outputs one more
    task automatic settle();
        repeat (8) @(posedge clk_sys_i);
    endtask
    task automatic drv(input logic [5:0] e, input string what);
        chk({26'h0, hs, ls}, {26'h0, e}, what);
    endtask
    // hang guard
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        void'($urandom(48312));
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        settle();
        chk(sleep, 1'b1, "sleep after reset");
        apb(1'b0, OFF_LOCK, 32'h0);
        chk(rd, 32'h0000_0fa0, "lock reset");
        apb(1'b0, 8'h0c, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped read");
        apb(1'b1, OFF_LOCK, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h1);
        wake <= 1'b1;
        settle();
        chk({sleep, reg_en}, 2'h1, "speed wake");
        // random sectors, directions and tach ratio; selects always driven
        // rotor stands in one sector per step, so reversal is at standstill
        repeat (16) begin
            sector <= 3'($urandom % 6); fwd <= 1'($urandom); tsel <= 1'($urandom);
            settle();
            drv(exp_drv(sector, fwd), "commutation");
            chk(tach, tsel ? ^hall : hall[0], "tach");
        end
        fwd <= 1'b0; fwd_open <= 1'b1; settle();
        drv(exp_drv(sector, 1'b1), "open rotation");
        fwd_open <= 1'b0; fwd <= 1'b1; brk <= 1'b1; settle();
        drv(6'h07, "brake");
        brk <= 1'b0; brk_open <= 1'b1; settle();
        drv(6'h07, "open brake");
        brk_open <= 1'b0; settle();
        brk <= 1'b1; @(posedge clk_sys_i); brk <= 1'b0; settle();
        drv(exp_drv(sector, 1'b1), "glitch");
        // off timer after a current event, both modes and both decay levels
        pwm <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, OFF_CTRL, {31'h0, m[1]});
            dec <= m[0]; settle();
            st = m[0] ? OFF_SHORT_CYC : OFF_LONG_CYC;
            if (m[1]) peak <= 1'b1; else ocp <= 1'b1;
            @(posedge clk_sys_i);
            peak <= 1'b0; ocp <= 1'b0;
            repeat (st - 10) @(posedge clk_sys_i);
            drv(6'h00, "off time");
            repeat (15) @(posedge clk_sys_i);
            drv(exp_drv(sector, 1'b1), "resume");
        end
        wake <= 1'b0; settle();
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rd[1:0], 2'h2, "speed low free");
        wake <= 1'b1; spd_open <= 1'b1; settle();
        drv(6'h00, "speed open");
        spd_open <= 1'b0;
        apb(1'b1, OFF_CTRL, 32'h0);
        pwm_open <= 1'b1; settle();
        drv(6'h00, "pwm open");
        pwm_open <= 1'b0; settle();
        drv(exp_drv(sector, 1'b1), "pwm low drive");
        pwm <= 1'b1; settle();
        drv(6'h18, "upper brake");
        repeat (50) @(posedge clk_sys_i);
        apb(1'b0, OFF_STAT, 32'h0);
        chk({rd[1:0], 20'h0, hs, ls}, 28'h800_0000, "zero duty free");
        apb(1'b1, OFF_LOCK, 32'h1);
        repeat (40) @(posedge clk_sys_i);
        chk(sleep, 1'b1, "lock sleep");
        pwm <= 1'b0; settle();
        chk({sleep, reg_en}, 2'h1, "pwm wake");
        summarize();
    end
endmodule
